// ==== rsc_device.sv ====
// Summary of operation
// - Device samples input bit on rising clock
// - High select resets serial shift state
// - Command code then command-specific parameter bits
// - Sixteen-bit words travel MSB first
// - Power-on reset loads default register values
// - Enabled event pulls request line low
// - Transmit register free raises ready event
// - FIFO bit count reaching level raises event
// - Overflow or underrun raise shared error event
// - Wake timer expiry raises event
// - Low pulse on external pin raises event
// - Low supply or power-on raises event
// - FIFO events only in FIFO mode
// - Transmit events only with TX register
// - Host reads status after request
// - Commands ignored during power-on timeout; the status command is still read out and clears the flags
// - Wake timer ticks about each millisecond
// - Eight output power levels 3 dB apart
// - Control bit one enables its function
// - Status command shifts pending bits out
//
// Purpose: Device end: serial command port, control registers, service request
// Assumes: sck is the link clock; event inputs are levels on CLK_SYS
// Notes:   Commands are applied in CLK_SYS after a toggle crossing
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_device #(
  parameter int POR_CYCLES = `RSC_POR_CYC
) (
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  input  wire logic           CE,
  rsc_link_if.device          LINK,
  input  wire logic           TX_REG_FREE,
  input  wire logic           TX_REG_UNDERRUN,
  input  wire logic           RX_BIT_STROBE,
  input  wire logic           RX_FIFO_FULL,
  input  wire logic           WAKE_TICK,
  input  wire logic           EXTERNAL_EVENT_IN_LOW,
  input  wire logic           SUPPLY_LOW,
  output logic [15:0]         CONFIG_WORD,
  output logic [15:0]         POWER_WORD,
  output logic [15:0]         TXCFG_WORD,
  output logic [7:0]          TX_DATA,
  output logic                TX_DATA_STROBE,
  output logic [2:0]          TX_POWER_STEP
);
  ////////////////////////////////////////////////////////////////////////////
  // Link domain: shift register, reset while select is high
  logic [`RSC_CMD_MSB:0]      shift;
  logic [`RSC_BITCNT_W-1:0]   bit_cnt;
  logic [`RSC_CMD_MSB:0]      cmd_word;
  logic                       cmd_tgl;
  logic [`RSC_STAT_W-1:0]     stat_shift;
  logic [`RSC_STAT_W-1:0]     stat_snap_sync;
  logic                       stat_tgl;

  // Select high acts as async reset of the shift register and bit count
  always_ff @(posedge LINK.sck or posedge LINK.select_low or posedge RESET)
    if (RESET || LINK.select_low)
    begin
      shift   <= '0;
      bit_cnt <= '0;
    end
    else
    begin
      shift   <= {shift[`RSC_CMD_MSB-1:0], LINK.serial_command_in};
      if (bit_cnt != `RSC_BITCNT_W'(`RSC_CMD_BITS))
        bit_cnt <= bit_cnt + 1'b1;
    end

  // Whole words only are handed over; a short frame never toggles
  always_ff @(posedge LINK.sck or posedge RESET)
    if (RESET)
    begin
      cmd_word <= '0;
      cmd_tgl  <= 1'b0;
    end
    else if (!LINK.select_low && bit_cnt == `RSC_BITCNT_W'(`RSC_CMD_BITS-1))
    begin
      cmd_word <= {shift[`RSC_CMD_MSB-1:0], LINK.serial_command_in};
      cmd_tgl  <= ~cmd_tgl;
    end

  // Status word shifts out MSB first during a status command
  always_ff @(negedge LINK.sck or posedge RESET)
    if (RESET)
      stat_shift <= '0;
    else if (bit_cnt == `RSC_BITCNT_W'(`RSC_OP_BITS))
      stat_shift <= stat_snap_sync;
    else
      stat_shift <= {stat_shift[`RSC_STAT_W-2:0], 1'b0};

  assign LINK.serial_data_out = stat_shift[`RSC_STAT_W-1];

  // Status clear event back to CLK_SYS when the status opcode arrived
  always_ff @(posedge LINK.sck or posedge RESET)
    if (RESET)
      stat_tgl <= 1'b0;
    else if (!LINK.select_low && bit_cnt == `RSC_BITCNT_W'(`RSC_OP_BITS-1) &&
             {shift[`RSC_OP_BITS-2:0], LINK.serial_command_in} == `RSC_OP_STATUS)
      stat_tgl <= ~stat_tgl;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings into CLK_SYS
  logic [2:0] cmd_sync;
  logic [2:0] stat_sync;
  logic [2:0] ext_sync;
  logic       cmd_seen;
  logic       stat_seen;
  logic       ext_state;

  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      cmd_sync  <= '0;
      stat_sync <= '0;
      ext_sync  <= 3'h7;
    end
    else if (CE)
    begin
      cmd_sync  <= {cmd_sync[1:0], cmd_tgl};
      stat_sync <= {stat_sync[1:0], stat_tgl};
      ext_sync  <= {ext_sync[1:0], EXTERNAL_EVENT_IN_LOW};
    end

  // Second and third stage must agree before a change counts
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      cmd_seen  <= 1'b0;
      stat_seen <= 1'b0;
      ext_state <= 1'b1;
    end
    else if (CE)
    begin
      if (cmd_sync[1] == cmd_sync[2])
        cmd_seen <= cmd_sync[2];
      if (stat_sync[1] == stat_sync[2])
        stat_seen <= stat_sync[2];
      if (ext_sync[1] == ext_sync[2])
        ext_state <= ext_sync[2];
    end

  logic cmd_new;
  logic stat_clr;
  logic ext_fall;
  assign cmd_new  = (cmd_sync[2] == cmd_sync[1]) && (cmd_sync[2] != cmd_seen);
  assign stat_clr = (stat_sync[2] == stat_sync[1]) && (stat_sync[2] != stat_seen);
  assign ext_fall = (ext_sync[2] == ext_sync[1]) && ext_state && !ext_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // Power-on timeout: commands other than status ignored until it expires
  logic [31:0] por_cnt;
  logic        por_done;
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      por_cnt  <= '0;
      por_done <= 1'b0;
    end
    else if (CE && !por_done)
    begin
      por_cnt <= por_cnt + 1'b1;
      if (por_cnt >= 32'(POR_CYCLES - 1))
        por_done <= 1'b1;
    end

  logic       cmd_ok;
  logic [7:0] op;
  assign cmd_ok = cmd_new && por_done;
  assign op     = cmd_word[15:8];

  // Control registers; cmd_word is stable long before the toggle is seen
  logic [15:0] fifo_word;
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      CONFIG_WORD    <= `RSC_CONFIG_POR;
      POWER_WORD     <= `RSC_POWER_POR;
      fifo_word      <= `RSC_FIFO_POR;
      TXCFG_WORD     <= `RSC_TXCFG_POR;
      TX_DATA        <= '0;
      TX_DATA_STROBE <= 1'b0;
      TX_POWER_STEP  <= '0;
    end
    else if (CE)
    begin
      TX_DATA_STROBE <= 1'b0;
      if (cmd_ok)
        case (op)
          `RSC_OP_CONFIG:  CONFIG_WORD <= cmd_word;
          `RSC_OP_POWER:   POWER_WORD  <= cmd_word;
          `RSC_OP_FIFO:    fifo_word   <= cmd_word;
          `RSC_OP_TXCFG:
          begin
            TXCFG_WORD    <= cmd_word;
            TX_POWER_STEP <= cmd_word[`RSC_TXPWR_W-1:0];
          end
          `RSC_OP_TXWRITE:
          begin
            TX_DATA        <= cmd_word[7:0];
            TX_DATA_STROBE <= 1'b1;
          end
          default: ;
        endcase
    end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: set wins over the clear by a status read
  logic fifo_en;
  logic txreg_en;
  logic [`RSC_FIFO_LVL_W-1:0] lvl;
  logic [`RSC_FIFO_LVL_W:0]   rx_bits;
  logic [`RSC_STAT_W-1:0]     ev;
  logic [`RSC_STAT_W-1:0]     flags;
  logic                       lowv_d;
  logic                       por_ev;

  assign fifo_en  = CONFIG_WORD[`RSC_CFG_FIFO_BIT];
  assign txreg_en = CONFIG_WORD[`RSC_CFG_TXREG_BIT];
  assign lvl      = fifo_word[`RSC_FIFO_LVL_LSB +: `RSC_FIFO_LVL_W];

  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      rx_bits <= '0;
      lowv_d  <= 1'b0;
      por_ev  <= 1'b1;
    end
    else if (CE)
    begin
      por_ev <= 1'b0;
      lowv_d <= SUPPLY_LOW;
      if (!fifo_en || ev[`RSC_ST_FFLVL])
        rx_bits <= '0;
      else if (RX_BIT_STROBE)
        rx_bits <= rx_bits + 1'b1;
    end

  always_comb
  begin
    ev = '0;
    ev[`RSC_ST_TXRDY] = txreg_en && TX_REG_FREE;
    ev[`RSC_ST_FFLVL] = fifo_en && lvl != '0 &&
                        rx_bits == {1'b0, lvl};
    ev[`RSC_ST_POR]   = por_ev;
    ev[`RSC_ST_ERR]   = (fifo_en && RX_FIFO_FULL && RX_BIT_STROBE) ||
                        (txreg_en && TX_REG_UNDERRUN);
    ev[`RSC_ST_WAKE]  = POWER_WORD[`RSC_PWR_WAKE_BIT] && WAKE_TICK;
    ev[`RSC_ST_EXT]   = ext_fall;
    ev[`RSC_ST_LOWV]  = POWER_WORD[`RSC_PWR_LOWV_BIT] && SUPPLY_LOW && !lowv_d;
  end

  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
      flags <= '0;
    else if (CE)
      flags <= (stat_clr ? '0 : flags) | ev;

  // Snapshot for the serial status read
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
      stat_snap_sync <= '0;
    else if (CE)
      stat_snap_sync <= flags;

  logic req_low;
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
      req_low <= 1'b1;
    else if (CE)
      req_low <= ~|flags;

  assign LINK.service_request_low = req_low;
endmodule
`default_nettype wire

// ==== rsc_host.sv ====
// Purpose: Host end: shifts 16-bit commands out, captures the returned word and flags a pending request
// Assumes: sck derived from CLK_SYS by a divider
// Notes:   One command at a time; DONE pulses when the frame ends
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"
module rsc_host (
  input  wire logic           CLK_SYS,
  input  wire logic           RESET,
  input  wire logic           CE,
  rsc_link_if.host            LINK,
  input  wire logic           CMD_VALID,
  input  wire logic [15:0]    CMD_WORD,
  output logic                CMD_READY,
  output logic                DONE,
  output logic [15:0]         READ_WORD,
  output logic                REQUEST_PENDING
);
  rsc_pkg::rsc_host_state_t state;
  logic [15:0] sh;
  logic [15:0] rd;
  logic [4:0]  cnt;
  logic [2:0]  div;
  logic        sck;
  logic [2:0]  irq_sync;

  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      state <= rsc_pkg::RSC_H_IDLE;
      sh <= '0; rd <= '0; cnt <= '0; div <= '0; sck <= 1'b0;
      LINK.select_low <= 1'b1;
      LINK.serial_command_in <= 1'b0;
      CMD_READY <= 1'b0;
      DONE <= 1'b0;
      READ_WORD <= '0;
    end
    else if (CE)
    begin
      DONE <= 1'b0;
      case (state)
        rsc_pkg::RSC_H_IDLE:
        begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY)
          begin
            CMD_READY <= 1'b0;
            LINK.select_low <= 1'b0;
            LINK.serial_command_in <= CMD_WORD[`RSC_CMD_MSB];
            sh <= {CMD_WORD[`RSC_CMD_MSB-1:0], 1'b0};
            cnt <= '0; div <= '0;
            state <= rsc_pkg::RSC_H_SHIFT;
          end
        end
        rsc_pkg::RSC_H_SHIFT:
        begin
          div <= div + 1'b1;
          if (div == 3'(`RSC_SCK_DIV/2 - 1))
          begin
            sck <= 1'b1;
            rd  <= {rd[14:0], LINK.serial_data_out};
          end
          else if (div == 3'(`RSC_SCK_DIV - 1))
          begin
            sck <= 1'b0;
            cnt <= cnt + 1'b1;
            LINK.serial_command_in <= sh[`RSC_CMD_MSB];
            sh <= {sh[`RSC_CMD_MSB-1:0], 1'b0};
            if (cnt == 5'(`RSC_CMD_BITS - 1))
              state <= rsc_pkg::RSC_H_GAP;
          end
        end
        rsc_pkg::RSC_H_GAP:
        begin
          LINK.select_low <= 1'b1;
          READ_WORD <= rd;
          DONE <= 1'b1;
          state <= rsc_pkg::RSC_H_IDLE;
        end
        default: state <= rsc_pkg::RSC_H_IDLE;
      endcase
    end

  assign LINK.sck = sck;

  // Request line from the device crosses with three stages
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET)
    begin
      irq_sync <= 3'h7;
      REQUEST_PENDING <= 1'b0;
    end
    else if (CE)
    begin
      irq_sync <= {irq_sync[1:0], LINK.service_request_low};
      if (irq_sync[1] == irq_sync[2])
        REQUEST_PENDING <= ~irq_sync[2];
    end
endmodule
`default_nettype wire

// ==== rsc_link_if.sv ====
// Purpose: Serial link between host and radio control port
// Assumes: Select and data driven by host, request line by device
// Notes:   No clocking block
`timescale 1ns/1ps
`default_nettype none
interface rsc_link_if;
  logic sck;
  logic select_low;
  logic serial_command_in;
  logic serial_data_out;
  logic service_request_low;
  modport host   (output sck, output select_low, output serial_command_in,
                  input serial_data_out, input service_request_low);
  modport device (input sck, input select_low, input serial_command_in,
                  output serial_data_out, output service_request_low);
endinterface
`default_nettype wire

// ==== rsc_link_properties.sv ====
// Purpose: Link-level checks on the host to device serial link
// Assumes: sck is slow enough to be sampled as a level on CLK_SYS
// Notes:   Watches the interface that joins the two design ends
`timescale 1ns/1ps
`default_nettype none
module rsc_link_properties (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic sck,
  input wire logic select_low,
  input wire logic serial_command_in,
  input wire logic serial_data_out,
  input wire logic service_request_low
);
  logic       sck_q;
  logic [4:0] bit_cnt;
  logic [7:0] idle_cnt;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET) sck_q <= 1'b0;
    else sck_q <= sck;
  // Bits of the current frame
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET) bit_cnt <= 5'h00;
    else if (select_low) bit_cnt <= 5'h00;
    else if (sck && !sck_q) bit_cnt <= bit_cnt + 5'h01;
  // Cycles since the select line was last low, saturating
  always_ff @(posedge CLK_SYS or posedge RESET)
    if (RESET) idle_cnt <= 8'hFF;
    else if (!select_low) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
  ////////////////////////////////////////////////////////////////////////////
  chk_sck_in_frame: assert property ($rose(sck) |-> !select_low)
    else $error("sck rose outside a frame");
  chk_data_steady: assert property ($rose(sck) |-> $stable(serial_command_in))
    else $error("data changed at sck rise");
  chk_sck_high_time: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("sck high time wrong");
  chk_select_setup: assert property ($fell(select_low) |-> !sck [*4])
    else $error("sck rose too soon after select");
  chk_word_length: assert property ($rose(select_low) |-> bit_cnt == 5'h10)
    else $error("frame not sixteen bits");
  chk_sck_idle: assert property (select_low |-> !sck)
    else $error("sck not idle low");
  chk_select_gap: assert property ($rose(select_low) |=> select_low)
    else $error("select high gap too short");
  chk_request_release: assert property ($rose(service_request_low) |-> idle_cnt < 8'h40)
    else $error("request released without a frame");
  cover property ($rose(select_low));
  cover property ($fell(service_request_low));
  cover property ($rose(service_request_low));
endmodule
`default_nettype wire

// ==== rsc_pkg.sv ====
// Purpose: Shared types of the radio serial control block
// Assumes: Constants come from rsc_regs.svh
// Notes:   Types only
`include "rsc_regs.svh"
package rsc_pkg;
  typedef logic [`RSC_CMD_MSB:0]    rsc_word_t;
  typedef logic [`RSC_STAT_W-1:0]   rsc_status_t;
  typedef enum logic [1:0] {RSC_H_IDLE, RSC_H_SHIFT, RSC_H_GAP} rsc_host_state_t;
endpackage

// ==== rsc_regs.svh ====
// Purpose: Named constants for the radio serial control port and service request logic
// Assumes: Included by the package, both end modules and the bench
// Notes:   Definitions only
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

`define RSC_CMD_BITS        16
`define RSC_CMD_MSB         15
`define RSC_BITCNT_W        5
`define RSC_OP_CONFIG       8'h80
`define RSC_OP_POWER        8'h82
`define RSC_OP_FIFO         8'hCA
`define RSC_OP_TXCFG        8'h98
`define RSC_OP_TXWRITE      8'hB8
`define RSC_OP_STATUS       8'h00
`define RSC_CONFIG_POR      16'h8008
`define RSC_POWER_POR       16'h8208
`define RSC_FIFO_POR        16'hCA80
`define RSC_TXCFG_POR       16'h9800
`define RSC_CFG_TXREG_BIT   7
`define RSC_CFG_FIFO_BIT    6
`define RSC_FIFO_LVL_LSB    4
`define RSC_FIFO_LVL_W      4
`define RSC_TXPWR_W         3
`define RSC_OP_BITS         8
`define RSC_PWR_WAKE_BIT    1
`define RSC_PWR_LOWV_BIT    2
`define RSC_STAT_W          7
`define RSC_ST_TXRDY        0
`define RSC_ST_FFLVL        1
`define RSC_ST_POR          2
`define RSC_ST_ERR          3
`define RSC_ST_WAKE         4
`define RSC_ST_EXT          5
`define RSC_ST_LOWV         6
`define RSC_POR_MS          100
`define RSC_POR_CYC         (`RSC_POR_MS * 200000)
`define RSC_WAKE_MIN_US     950
`define RSC_WAKE_MAX_US     1050
`define RSC_RECAL_S         30
`define RSC_SCK_DIV         8

`endif

// ==== test_radio_serial_control_irq.sv ====
// Purpose: Self-checking bench for host and device ends of the serial control link
// Assumes: Status flags follow the opcode byte, ending at word bit 1
// Notes:   A second device on a bench-driven link takes broken frames
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"
module test_radio_serial_control_irq;
  logic        clk;
  logic        rst;
  logic        cmd_valid;
  logic [15:0] cmd_word;
  logic        cmd_ready;
  logic        done;
  logic [15:0] read_word;
  logic        pending;
  logic [6:0]  ev;
  logic [15:0] cfg_o;
  logic [15:0] pwr_o;
  logic [15:0] txc_o;
  logic [7:0]  txd_o;
  logic [2:0]  step_o;
  logic [15:0] cfg2_o;
  logic        strobe_o;
  int          strobes = 0;
  logic [15:0] wire_sr;
  logic [15:0] cfg;
  logic [31:0] r;
  logic [6:0]  f;
  logic [6:0]  e;
  int          failures;
  int          checked;
  int          i;
  rsc_link_if link ();
  rsc_link_if link2 ();
  ////////////////////////////////////////////////////////////////////////////
  rsc_host rsc_host_inst (.CLK_SYS(clk), .RESET(rst), .CE(1'b1), .LINK(link),
    .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CMD_READY(cmd_ready), .DONE(done),
    .READ_WORD(read_word), .REQUEST_PENDING(pending));
  rsc_device #(.POR_CYCLES(400)) rsc_device_inst (.CLK_SYS(clk), .RESET(rst), .CE(1'b1),
    .LINK(link), .TX_REG_FREE(ev[0]), .TX_REG_UNDERRUN(ev[3]), .RX_BIT_STROBE(ev[1]),
    .RX_FIFO_FULL(ev[2]), .WAKE_TICK(ev[4]), .EXTERNAL_EVENT_IN_LOW(~ev[5]),
    .SUPPLY_LOW(ev[6]), .CONFIG_WORD(cfg_o), .POWER_WORD(pwr_o), .TXCFG_WORD(txc_o),
    .TX_DATA(txd_o), .TX_DATA_STROBE(strobe_o), .TX_POWER_STEP(step_o));
  rsc_device #(.POR_CYCLES(50)) rsc_device_2_inst (.CLK_SYS(clk), .RESET(rst), .CE(1'b1),
    .LINK(link2), .TX_REG_FREE(ev[0]), .TX_REG_UNDERRUN(ev[3]), .RX_BIT_STROBE(ev[1]),
    .RX_FIFO_FULL(ev[2]), .WAKE_TICK(ev[4]), .EXTERNAL_EVENT_IN_LOW(~ev[5]),
    .SUPPLY_LOW(ev[6]), .CONFIG_WORD(cfg2_o), .POWER_WORD(), .TXCFG_WORD(),
    .TX_DATA(), .TX_DATA_STROBE(), .TX_POWER_STEP());
  rsc_link_properties rsc_link_properties_inst (.CLK_SYS(clk), .RESET(rst), .sck(link.sck),
    .select_low(link.select_low), .serial_command_in(link.serial_command_in),
    .serial_data_out(link.serial_data_out), .service_request_low(link.service_request_low));
  // One strobe per accepted transmit write
  always @(posedge clk)
    if (strobe_o === 1'b1)
      strobes++;
  always @(posedge link.sck)
    wire_sr <= {wire_sr[14:0], link.serial_command_in};
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Called just after a clock edge; holds the request until ready is sampled
  task automatic send(input logic [15:0] w);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_word <= w;
    do @(posedge clk); while (cmd_ready !== 1'b1 && n++ < 400);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && n++ < 800) @(posedge clk);
    repeat (40) @(posedge clk);
    check(wire_sr, w);
  endtask
  task automatic status(output logic [6:0] s);
    send(16'h0000);
    s = read_word[7:1];
  endtask
  // Bit k of ev drives status source k, bit 2 the FIFO full input of source 3; source 2 fires nothing
  task automatic fire(input int k);
    logic [6:0] m;
    m = (k == 3) ? 7'h0E : (k == 2) ? 7'h00 : 7'h01 << k;
    repeat (16)
    begin
      ev <= m;
      repeat (3) @(posedge clk);
      ev <= m & 7'h04;
      repeat (3) @(posedge clk);
    end
    ev <= 7'h00;
    repeat (20) @(posedge clk);
  endtask
  // Bench-made link clock, 80 ns, offset from the system clock
  task automatic bang(input logic [15:0] w, input int n);
    #1.3 link2.select_low = 1'b0;
    for (int b = 15; b > 15 - n; b--)
    begin
      link2.serial_command_in = w[b];
      #40 link2.sck = 1'b1;
      #40 link2.sck = 1'b0;
    end
    #20 link2.select_low = 1'b1;
    link2.serial_command_in = ~w[16-n];
    #300;
  endtask
  function automatic logic [6:0] expect_flags(input int k, input logic [15:0] c,
                                              input logic [15:0] p);
    logic [6:0] x;
    x = 7'h00;
    case (k)
      0: x[0] = c[7];
      1: x[1] = c[6];
      3: x = {3'h0, c[7] | c[6], 1'b0, c[6], 1'b0};
      4: x[4] = p[1];
      5: x[5] = 1'b1;
      6: x[6] = p[2];
      default: x = 7'h00;
    endcase
    return x;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    // About 15,000 cycles of tests; allow a wide margin, still far under the run limit
    #300000;
    failures++;
    end_sim();
  end
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
    ev = 7'h00;
    failures = 0;
    checked = 0;
    link2.sck = 1'b0;
    link2.select_low = 1'b1;
    link2.serial_command_in = 1'b0;
    r = $urandom(32'h0F8E);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(cfg_o, `RSC_CONFIG_POR);
    check(pwr_o, `RSC_POWER_POR);
    check(txc_o, `RSC_TXCFG_POR);
    send(16'h80C0);
    check(cfg_o, `RSC_CONFIG_POR);
    repeat (300) @(posedge clk);
    check(16'(pending), 16'h0001);
    status(f);
    check(16'(f), 16'h0004);
    check(16'(pending), 16'h0000);
    bang(16'h80FF, 12);
    check(cfg2_o, `RSC_CONFIG_POR);
    bang(16'h80A5, 16);
    check(cfg2_o, 16'h80A5);
    @(posedge clk);
    for (i = 0; i < 14; i++)
    begin
      r = $urandom;
      // First half sets every source enable bit, second half clears them
      r[7:6] = {2{i < 7}};
      r[10:9] = {2{i < 7}};
      cfg = {8'h80, r[7:0]};
      send(cfg);
      send({8'h82, r[15:8]});
      send({8'h98, r[23:16]});
      send({8'hB8, r[31:24]});
      check(cfg_o, cfg);
      check(pwr_o, {8'h82, r[15:8]});
      check(txc_o, {8'h98, r[23:16]});
      check(16'(step_o), 16'(r[18:16]));
      check(16'(txd_o), 16'(r[31:24]));
      check(16'(strobes), 16'(i + 1));
      e = expect_flags(i % 7, cfg, {8'h82, r[15:8]});
      fire(i % 7);
      check(16'(pending), 16'(|e));
      status(f);
      check(16'(f), 16'(e));
      check(16'(pending), 16'h0000);
    end
    end_sim();
  end
endmodule
`default_nettype wire
